// ---- periph_clk_div.sv ----
// One peripheral clock divider producing an enable pulse
`timescale 1ns/10ps
module periph_clk_div (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic [power_mode_pkg::DIV_W-1:0] ratio,
  output logic tick
);
  typedef struct packed {
    logic [power_mode_pkg::DIV_W-1:0] cnt;
    logic tick;
  } div_state_type;

  div_state_type s_r;
  div_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run || ratio == power_mode_pkg::DIV_ZERO) begin
      s_nxt.cnt = power_mode_pkg::DIV_ZERO;
    end else if (s_r.cnt >= ratio - power_mode_pkg::DIV_ONE) begin
      s_nxt.cnt = power_mode_pkg::DIV_ZERO;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + power_mode_pkg::DIV_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule : periph_clk_div

// ---- power_mode_ctrl.sv ----
// System power mode controller: modes, wakeup, clock sources and radio mode gating
//
// What this block does
// - Active mode is the main mode and keeps every peripheral available.
// - Sleep halts CPU, retains SRAM, keeps peripherals; any interrupt returns to Active.
// - Deep-Sleep stops main oscillator and fast peripherals; watch crystal runs, other slow clocks optionally run.
// - Deep-Sleep wakes only on slow, asynchronous or low-power analog interrupts.
// - Hibernate keeps SRAM and wakes only on comparator or general pin interrupt.
// - Stop holds pin states and wakes only on the dedicated wakeup pin.
// - Radio active states only in Active/Sleep; radio deep-sleep also in Deep-Sleep; else off.
// - CPU and fast peripherals clock from main oscillator or fast crystal, via dividers.
// - Main oscillator frequency is selectable 3 to 48 MHz in 1 MHz steps.
// - Fast crystal makes 24 MHz, feeds radio, may source the system clock.
// - Slow system clock comes from watch crystal or low-speed internal oscillator.
// - Watch crystal runs in all modes but Hibernate and Stop; it times radio events.
`timescale 1ns/10ps
module power_mode_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode_req_valid,
  input power_mode_pkg::sys_mode_type mode_req,
  input wire logic lf_keep_in_deep_sleep,
  input wire logic hf_src_req,
  input wire logic lf_src_req,
  input wire logic freq_req_valid,
  input wire logic [power_mode_pkg::FREQ_W-1:0] freq_req_mhz,
  input wire logic radio_req_valid,
  input power_mode_pkg::radio_state_type radio_req,
  input wire logic [power_mode_pkg::NUM_DIV-1:0][power_mode_pkg::DIV_W-1:0] div_ratio,
  input wire logic irq_any,
  input wire logic irq_low_speed,
  input wire logic irq_async,
  input wire logic irq_lp_analog,
  input wire logic lp_comp_irq,
  input wire logic gpio_irq,
  input wire logic wakeup_pin,
  output power_mode_pkg::sys_mode_type sys_mode,
  output power_mode_pkg::radio_state_type radio_state,
  output logic cpu_halt,
  output logic sram_retain,
  output logic hs_periph_en,
  output logic ls_periph_en,
  output logic gpio_hold,
  output logic main_internal_oscillator_en,
  output logic [power_mode_pkg::FREQ_W-1:0] main_internal_oscillator_mhz,
  output logic fast_crystal_oscillator_en,
  output logic watch_crystal_oscillator_en,
  output logic low_speed_internal_oscillator_en,
  output logic high_freq_system_clock_src,
  output logic low_freq_system_clock_src,
  output logic radio_subsystem_power,
  output logic radio_timebase_ok,
  output logic wake_event,
  output logic mode_req_refused,
  output logic radio_req_refused,
  output logic freq_req_refused,
  output logic [power_mode_pkg::NUM_DIV-1:0] hs_periph_clk_tick
);
  // Whole controller state, registered once per clock
  typedef struct packed {
    power_mode_pkg::sys_mode_type mode;
    power_mode_pkg::radio_state_type radio;
    logic [power_mode_pkg::SETTLE_W-1:0] settle_cnt;
    logic [power_mode_pkg::FREQ_W-1:0] osc_mhz;
    logic hf_src;
    logic lf_src;
    logic cpu_halt;
    logic sram_retain;
    logic hs_en;
    logic ls_en;
    logic gpio_hold;
    logic main_osc_en;
    logic fast_xtal_en;
    logic watch_xtal_en;
    logic lsi_en;
    logic radio_pwr;
    logic timebase_ok;
    logic wake_event;
    logic mode_refused;
    logic radio_refused;
    logic freq_refused;
  } pmc_state_type;

  pmc_state_type s_r;
  pmc_state_type s_nxt;
  // Wakeup from the sources that the current mode allows
  logic wake;

  wake_qualifier u_wake (
    .mclk(mclk),
    .rst(rst),
    .mode(s_r.mode),
    .irq_any(irq_any),
    .irq_low_speed(irq_low_speed),
    .irq_async(irq_async),
    .irq_lp_analog(irq_lp_analog),
    .lp_comp_irq(lp_comp_irq),
    .gpio_irq(gpio_irq),
    .wakeup_pin(wakeup_pin),
    .wake(wake)
  );

  // Dividers derive fast peripheral clocks from the selected high-frequency source
  genvar gi;
  generate
    for (gi = 0; gi < power_mode_pkg::NUM_DIV; gi++) begin : g_div
      periph_clk_div u_div (
        .mclk(mclk),
        .rst(rst),
        .run(s_r.hs_en),
        .ratio(div_ratio[gi]),
        .tick(hs_periph_clk_tick[gi])
      );
    end
  endgenerate

  // Radio states allowed in each system mode
  function automatic logic radio_allowed(input power_mode_pkg::sys_mode_type m,
                                         input power_mode_pkg::radio_state_type r);
    logic ok;
    ok = 1'b0;
    unique case (m)
      power_mode_pkg::mode_active,
      power_mode_pkg::mode_sleep: ok = (r != power_mode_pkg::radio_off);
      power_mode_pkg::mode_deep_sleep: ok = (r == power_mode_pkg::radio_deep_sleep);
      power_mode_pkg::mode_hibernate,
      power_mode_pkg::mode_stop: ok = (r == power_mode_pkg::radio_off);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : radio_allowed

  // Mode sequencing, request checks and per-mode resources
  always_comb begin
    s_nxt = s_r;
    s_nxt.wake_event = 1'b0;
    s_nxt.mode_refused = 1'b0;
    s_nxt.radio_refused = 1'b0;
    s_nxt.freq_refused = 1'b0;

    unique case (s_r.mode)
      power_mode_pkg::mode_active: begin
        // Clock sources change only while running, never mid-transition
        s_nxt.hf_src = hf_src_req;
        s_nxt.lf_src = lf_src_req;
        // Out-of-range frequency refused, old setting kept
        if (freq_req_valid) begin
          if (freq_req_mhz >= power_mode_pkg::MAIN_OSC_MIN_MHZ &&
              freq_req_mhz <= power_mode_pkg::MAIN_OSC_MAX_MHZ) begin
            s_nxt.osc_mhz = freq_req_mhz;
          end else begin
            s_nxt.freq_refused = 1'b1;
          end
        end
        if (mode_req_valid) begin
          unique case (mode_req)
            power_mode_pkg::mode_active: s_nxt.mode = power_mode_pkg::mode_active;
            power_mode_pkg::mode_sleep: s_nxt.mode = power_mode_pkg::mode_sleep;
            power_mode_pkg::mode_deep_sleep: begin
              // Radio must already rest in deep-sleep before the fast clock goes
              if (s_r.radio == power_mode_pkg::radio_deep_sleep) begin
                s_nxt.mode = power_mode_pkg::mode_deep_sleep;
              end else begin
                s_nxt.mode_refused = 1'b1;
              end
            end
            power_mode_pkg::mode_hibernate: begin
              s_nxt.mode = power_mode_pkg::mode_hibernate;
              s_nxt.radio = power_mode_pkg::radio_off;
            end
            power_mode_pkg::mode_stop: begin
              s_nxt.mode = power_mode_pkg::mode_stop;
              s_nxt.radio = power_mode_pkg::radio_off;
            end
            default: s_nxt.mode_refused = 1'b1;
          endcase
        end
      end
      power_mode_pkg::mode_sleep: begin
        // Fast clock still runs, so the return is immediate
        if (wake) begin
          s_nxt.mode = power_mode_pkg::mode_active;
          s_nxt.wake_event = 1'b1;
        end
      end
      power_mode_pkg::mode_deep_sleep,
      power_mode_pkg::mode_hibernate,
      power_mode_pkg::mode_stop: begin
        // Deeper modes restart the fast clock before running
        if (wake) begin
          s_nxt.mode = power_mode_pkg::mode_waking;
          s_nxt.settle_cnt = '0;
          s_nxt.wake_event = 1'b1;
          if (s_r.radio == power_mode_pkg::radio_off) begin
            s_nxt.radio = power_mode_pkg::radio_deep_sleep;
          end
        end
      end
      power_mode_pkg::mode_waking: begin
        // Hold fast peripherals off until the fast clock has settled
        if (s_r.settle_cnt == power_mode_pkg::SETTLE_LAST) begin
          s_nxt.mode = power_mode_pkg::mode_active;
        end else begin
          s_nxt.settle_cnt = s_r.settle_cnt + 1'b1;
        end
      end
      default: s_nxt.mode = power_mode_pkg::mode_active;
    endcase

    // Mode requests outside Active are ignored and flagged
    if (mode_req_valid && s_r.mode != power_mode_pkg::mode_active) begin
      s_nxt.mode_refused = 1'b1;
    end
    // Radio request judged against the mode being entered
    if (radio_req_valid && !s_nxt.mode_refused) begin
      if (radio_allowed(s_nxt.mode, radio_req)) begin
        s_nxt.radio = radio_req;
      end else begin
        s_nxt.radio_refused = 1'b1;
      end
    end

    // Per-mode resources, computed from the next mode so outputs track it
    s_nxt.cpu_halt = (s_nxt.mode != power_mode_pkg::mode_active);
    s_nxt.sram_retain = (s_nxt.mode == power_mode_pkg::mode_sleep) ||
                        (s_nxt.mode == power_mode_pkg::mode_deep_sleep) ||
                        (s_nxt.mode == power_mode_pkg::mode_hibernate);
    s_nxt.hs_en = (s_nxt.mode == power_mode_pkg::mode_active) ||
                  (s_nxt.mode == power_mode_pkg::mode_sleep);
    s_nxt.gpio_hold = (s_nxt.mode == power_mode_pkg::mode_stop);
    s_nxt.radio_pwr = (s_nxt.radio != power_mode_pkg::radio_off);

    // Fast clock restarts already during waking
    s_nxt.main_osc_en = (s_nxt.hs_en || s_nxt.mode == power_mode_pkg::mode_waking) &&
                        (s_nxt.hf_src == power_mode_pkg::HF_SRC_MAIN_OSC);
    s_nxt.fast_xtal_en = (s_nxt.hs_en || s_nxt.mode == power_mode_pkg::mode_waking) &&
                         (s_nxt.hf_src == power_mode_pkg::HF_SRC_FAST_XTAL ||
                          s_nxt.radio_pwr);

    // Slow clocks stop in Hibernate and Stop; in Deep-Sleep all but the watch crystal are optional
    if (s_nxt.mode == power_mode_pkg::mode_hibernate ||
        s_nxt.mode == power_mode_pkg::mode_stop) begin
      s_nxt.ls_en = 1'b0;
      s_nxt.watch_xtal_en = 1'b0;
      s_nxt.lsi_en = 1'b0;
    end else begin
      s_nxt.ls_en = (s_nxt.mode != power_mode_pkg::mode_deep_sleep) || lf_keep_in_deep_sleep;
      s_nxt.lsi_en = s_nxt.ls_en && (s_nxt.lf_src == power_mode_pkg::LF_SRC_LOW_SPEED_OSC);
      // Watch crystal keeps running while the radio needs its event timing
      s_nxt.watch_xtal_en = (s_nxt.ls_en && s_nxt.lf_src == power_mode_pkg::LF_SRC_WATCH_XTAL) ||
                            s_nxt.radio_pwr;
    end
    // Event timing needs radio power and the watch crystal
    s_nxt.timebase_ok = s_nxt.radio_pwr && s_nxt.watch_xtal_en;
  end

  // Radio parked in deep-sleep so Deep-Sleep entry is allowed at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
      s_r.mode <= power_mode_pkg::mode_active;
      s_r.radio <= power_mode_pkg::radio_deep_sleep;
      s_r.osc_mhz <= power_mode_pkg::MAIN_OSC_RST_MHZ;
      s_r.hf_src <= power_mode_pkg::HF_SRC_MAIN_OSC;
      s_r.lf_src <= power_mode_pkg::LF_SRC_LOW_SPEED_OSC;
      s_r.hs_en <= 1'b1;
      s_r.ls_en <= 1'b1;
      s_r.main_osc_en <= 1'b1;
      s_r.fast_xtal_en <= 1'b1;
      s_r.watch_xtal_en <= 1'b1;
      s_r.lsi_en <= 1'b1;
      s_r.radio_pwr <= 1'b1;
      s_r.timebase_ok <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a register bit
  assign sys_mode = s_r.mode;
  assign radio_state = s_r.radio;
  assign cpu_halt = s_r.cpu_halt;
  assign sram_retain = s_r.sram_retain;
  assign hs_periph_en = s_r.hs_en;
  assign ls_periph_en = s_r.ls_en;
  assign gpio_hold = s_r.gpio_hold;
  assign main_internal_oscillator_en = s_r.main_osc_en;
  assign main_internal_oscillator_mhz = s_r.osc_mhz;
  assign fast_crystal_oscillator_en = s_r.fast_xtal_en;
  assign watch_crystal_oscillator_en = s_r.watch_xtal_en;
  assign low_speed_internal_oscillator_en = s_r.lsi_en;
  assign high_freq_system_clock_src = s_r.hf_src;
  assign low_freq_system_clock_src = s_r.lf_src;
  assign radio_subsystem_power = s_r.radio_pwr;
  assign radio_timebase_ok = s_r.timebase_ok;
  assign wake_event = s_r.wake_event;
  assign mode_req_refused = s_r.mode_refused;
  assign radio_req_refused = s_r.radio_refused;
  assign freq_req_refused = s_r.freq_refused;
endmodule : power_mode_ctrl

// ---- power_mode_ctrl_monitor.sv ----
// Port-level assertions for the power mode controller
`timescale 1ns/10ps
module power_mode_ctrl_monitor (
  input wire logic mclk,
  input wire logic rst,
  input power_mode_pkg::sys_mode_type sys_mode,
  input power_mode_pkg::radio_state_type radio_state,
  input wire logic cpu_halt,
  input wire logic sram_retain,
  input wire logic hs_periph_en,
  input wire logic gpio_hold,
  input wire logic main_internal_oscillator_en,
  input wire logic [power_mode_pkg::FREQ_W-1:0] main_internal_oscillator_mhz,
  input wire logic watch_crystal_oscillator_en,
  input wire logic radio_subsystem_power,
  input wire logic irq_any,
  input wire logic gpio_irq,
  input wire logic lp_comp_irq,
  input wire logic wakeup_pin,
  input wire logic freq_req_valid,
  input wire logic [power_mode_pkg::FREQ_W-1:0] freq_req_mhz,
  input wire logic freq_req_refused
);
  int wait_cnt_r;
  // Cycles spent restarting the fast clock
  always_ff @(posedge mclk) begin
    if (rst || sys_mode != power_mode_pkg::mode_waking) begin
      wait_cnt_r <= 0;
    end else begin
      wait_cnt_r <= wait_cnt_r + 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_halt_follows_mode:
    assert property (cpu_halt == (sys_mode != power_mode_pkg::mode_active)) else $error("cpu halt wrong for mode");
  a_sleep_keeps_all:
    assert property (sys_mode == power_mode_pkg::mode_sleep |-> sram_retain && hs_periph_en)
    else $error("sleep lost sram or peripherals");
  a_sleep_any_wake:
    assert property (sys_mode == power_mode_pkg::mode_sleep && irq_any |-> ##2 sys_mode == power_mode_pkg::mode_active)
    else $error("sleep did not wake on interrupt");
  a_deep_fast_off:
    assert property (sys_mode == power_mode_pkg::mode_deep_sleep |-> !hs_periph_en && !main_internal_oscillator_en
      && radio_state == power_mode_pkg::radio_deep_sleep) else $error("deep sleep left fast logic or radio on");
  a_settle_not_long:
    assert property (sys_mode == power_mode_pkg::mode_waking |-> wait_cnt_r < power_mode_pkg::OSC_SETTLE_CYC)
    else $error("clock restart too long");
  a_settle_not_short:
    assert property (sys_mode == power_mode_pkg::mode_active && wait_cnt_r != 0
      |-> wait_cnt_r == power_mode_pkg::OSC_SETTLE_CYC) else $error("clock restart too short");
  a_hib_stays_put:
    assert property (sys_mode == power_mode_pkg::mode_hibernate && !lp_comp_irq && !gpio_irq && !$past(lp_comp_irq)
      && !$past(gpio_irq) |=> sys_mode == power_mode_pkg::mode_hibernate) else $error("hibernate left without cause");
  a_lowest_radio_off:
    assert property (sys_mode inside {power_mode_pkg::mode_hibernate, power_mode_pkg::mode_stop}
      |-> !radio_subsystem_power && !watch_crystal_oscillator_en) else $error("radio or watch crystal on");
  a_stop_pin_wake:
    assert property (sys_mode == power_mode_pkg::mode_stop && wakeup_pin
      |-> gpio_hold ##2 sys_mode == power_mode_pkg::mode_waking) else $error("stop pin wake failed");
  a_freq_bad_refused:
    assert property (freq_req_valid && sys_mode == power_mode_pkg::mode_active
      && (freq_req_mhz < power_mode_pkg::MAIN_OSC_MIN_MHZ || freq_req_mhz > power_mode_pkg::MAIN_OSC_MAX_MHZ)
      |=> freq_req_refused && $stable(main_internal_oscillator_mhz))
    else $error("bad frequency not refused");
endmodule : power_mode_ctrl_monitor

// ---- power_mode_ctrl_tb_top.sv ----
// Self-checking testbench for the power mode controller
`timescale 1ns/10ps
module power_mode_ctrl_tb_top;
  logic mclk, rst, mode_req_valid, lf_keep, hf_src_req, lf_src_req, freq_req_valid, radio_req_valid, fire;
  power_mode_pkg::sys_mode_type mode_req, sys_mode;
  power_mode_pkg::radio_state_type radio_req, radio_state;
  logic [5:0] freq_req_mhz, mhz;
  logic [3:0][7:0] div_ratio;
  logic [2:0] sel;
  logic [6:0] lines;
  logic cpu_halt, sram, hs_en, ls_en, gpio_hold, mio_en, fxo_en, wxo_en, lsio_en, hf_src, lf_src, radio_pwr;
  logic mode_ref, radio_ref, freq_ref, tbo, wake_ev;
  logic [3:0] tick;
  int err_total, checks;
  power_mode_ctrl i_power_mode_ctrl (.mclk(mclk), .rst(rst), .mode_req_valid(mode_req_valid), .mode_req(mode_req),
    .lf_keep_in_deep_sleep(lf_keep), .hf_src_req(hf_src_req), .lf_src_req(lf_src_req),
    .freq_req_valid(freq_req_valid), .freq_req_mhz(freq_req_mhz), .radio_req_valid(radio_req_valid),
    .radio_req(radio_req), .div_ratio(div_ratio), .irq_any(lines[0]), .irq_low_speed(lines[1]),
    .irq_async(lines[2]), .irq_lp_analog(lines[3]), .lp_comp_irq(lines[4]), .gpio_irq(lines[5]),
    .wakeup_pin(lines[6]), .sys_mode(sys_mode), .radio_state(radio_state), .cpu_halt(cpu_halt),
    .sram_retain(sram), .hs_periph_en(hs_en), .ls_periph_en(ls_en), .gpio_hold(gpio_hold),
    .main_internal_oscillator_en(mio_en), .main_internal_oscillator_mhz(mhz), .fast_crystal_oscillator_en(fxo_en),
    .watch_crystal_oscillator_en(wxo_en), .low_speed_internal_oscillator_en(lsio_en),
    .high_freq_system_clock_src(hf_src), .low_freq_system_clock_src(lf_src), .radio_subsystem_power(radio_pwr),
    .radio_timebase_ok(tbo), .wake_event(wake_ev), .mode_req_refused(mode_ref), .radio_req_refused(radio_ref),
    .freq_req_refused(freq_ref), .hs_periph_clk_tick(tick));
  wake_src_model i_wake_src_model (.fire(fire), .sel(sel), .lines(lines));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic req(input power_mode_pkg::sys_mode_type m);
    @(posedge mclk);
    mode_req_valid <= 1'h1;
    mode_req <= m;
    @(posedge mclk);
    mode_req_valid <= 1'h0;
    #1;
  endtask : req
  task automatic rreq(input power_mode_pkg::radio_state_type r);
    @(posedge mclk);
    radio_req_valid <= 1'h1;
    radio_req <= r;
    @(posedge mclk);
    radio_req_valid <= 1'h0;
    #1;
  endtask : rreq
  task automatic nowake(input logic [2:0] s, input power_mode_pkg::sys_mode_type m);
    @(posedge mclk);
    fire <= 1'h1;
    sel <= s;
    repeat (8) @(posedge mclk);
    fire <= 1'h0;
    #1;
    chk(8'(sys_mode), 8'(m));
  endtask : nowake
  task automatic wake(input logic [2:0] s);
    int n;
    int ev;
    @(posedge mclk);
    fire <= 1'h1;
    sel <= s;
    n = 0;
    ev = 0;
    while (sys_mode !== power_mode_pkg::mode_active && n < 1000) begin
      @(posedge mclk);
      #1;
      n++;
      ev += int'(wake_ev);
    end
    @(posedge mclk);
    fire <= 1'h0;
    #1;
    chk(8'(sys_mode), 8'(power_mode_pkg::mode_active));
    chk(8'({hs_en, cpu_halt}), 8'h02);
    chk(8'(ev), 8'h01);
  endtask : wake
  task automatic t_reset;
    chk(8'(sys_mode), 8'(power_mode_pkg::mode_active));
    chk(8'({hs_en, cpu_halt}), 8'h02);
    chk(8'(mhz), 8'h0c);
    req(power_mode_pkg::mode_waking);
    chk(8'({sys_mode, mode_ref}), 8'({power_mode_pkg::mode_active, 1'h1}));
    req(power_mode_pkg::mode_active);
    chk(8'({sys_mode, mode_ref}), 8'({power_mode_pkg::mode_active, 1'h0}));
  endtask : t_reset
  task automatic t_sleep;
    req(power_mode_pkg::mode_sleep);
    chk(8'({cpu_halt, sram, hs_en}), 8'h07);
    wake(3'h0);
  endtask : t_sleep
  task automatic t_deep;
    rreq(power_mode_pkg::radio_tx);
    chk(8'({radio_state, fxo_en}), 8'({power_mode_pkg::radio_tx, 1'h1}));
    rreq(power_mode_pkg::radio_off);
    chk(8'(radio_ref), 8'h01);
    req(power_mode_pkg::mode_deep_sleep);
    chk(8'({sys_mode, mode_ref}), 8'({power_mode_pkg::mode_active, 1'h1}));
    rreq(power_mode_pkg::radio_deep_sleep);
    for (int s = 1; s < 4; s++) begin
      @(posedge mclk);
      lf_keep <= 1'(s != 2);
      req(power_mode_pkg::mode_deep_sleep);
      chk(8'({hs_en, mio_en, ls_en, lsio_en, wxo_en, tbo}), 8'({2'h0, s != 2, s != 2, 2'h3}));
      rreq(power_mode_pkg::radio_idle);
      chk(8'(radio_ref), 8'h01);
      nowake(3'h0, power_mode_pkg::mode_deep_sleep);
      nowake(3'h6, power_mode_pkg::mode_deep_sleep);
      wake(3'(s));
    end
  endtask : t_deep
  task automatic t_low;
    for (int s = 4; s < 6; s++) begin
      req(power_mode_pkg::mode_hibernate);
      chk(8'({sram, radio_pwr, wxo_en, tbo}), 8'h08);
      req(power_mode_pkg::mode_active);
      chk(8'({sys_mode, mode_ref}), 8'({power_mode_pkg::mode_hibernate, 1'h1}));
      nowake(3'h6, power_mode_pkg::mode_hibernate);
      nowake(3'h2, power_mode_pkg::mode_hibernate);
      wake(3'(s));
    end
    req(power_mode_pkg::mode_stop);
    chk(8'({gpio_hold, radio_pwr}), 8'h02);
    nowake(3'h5, power_mode_pkg::mode_stop);
    nowake(3'h4, power_mode_pkg::mode_stop);
    wake(3'h6);
  endtask : t_low
  task automatic t_clk;
    logic [5:0] fv[4] = '{6'h30, 6'h31, 6'h02, 6'h03};
    logic [5:0] fe[4] = '{6'h30, 6'h30, 6'h30, 6'h03};
    int cnt[4] = '{0, 0, 0, 0};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      freq_req_valid <= 1'h1;
      freq_req_mhz <= fv[i];
      @(posedge mclk);
      freq_req_valid <= 1'h0;
      #1;
      chk(8'(freq_ref), 8'(fv[i] != fe[i]));
      repeat (2) @(posedge mclk);
      #1;
      chk(8'(mhz), 8'(fe[i]));
    end
    @(posedge mclk);
    hf_src_req <= 1'h1;
    lf_src_req <= 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    chk(8'({hf_src, fxo_en, mio_en}), 8'h06);
    chk(8'({lf_src, wxo_en, lsio_en}), 8'h06);
    repeat (40) begin
      @(posedge mclk);
      #1;
      for (int i = 0; i < 4; i++) cnt[i] += int'(tick[i]);
    end
    for (int i = 0; i < 4; i++) chk(8'(cnt[i]), 8'(40 >> i));
  endtask : t_clk
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
  initial begin
    {mode_req_valid, hf_src_req, lf_src_req, freq_req_valid, radio_req_valid, fire} = 6'h00;
    lf_keep = 1'h1;
    mode_req = power_mode_pkg::mode_active;
    radio_req = power_mode_pkg::radio_deep_sleep;
    freq_req_mhz = 6'h0c;
    div_ratio = {8'h08, 8'h04, 8'h02, 8'h01};
    sel = 3'h0;
    err_total = 0;
    checks = 0;
    rst = 1'h1;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    #1;
    t_reset();
    t_sleep();
    t_deep();
    t_low();
    t_clk();
    results();
  end
endmodule : power_mode_ctrl_tb_top
bind power_mode_ctrl power_mode_ctrl_monitor i_power_mode_ctrl_monitor (.mclk(mclk), .rst(rst), .sys_mode(sys_mode),
  .radio_state(radio_state), .cpu_halt(cpu_halt), .sram_retain(sram_retain), .hs_periph_en(hs_periph_en),
  .gpio_hold(gpio_hold), .main_internal_oscillator_en(main_internal_oscillator_en),
  .main_internal_oscillator_mhz(main_internal_oscillator_mhz), .watch_crystal_oscillator_en(watch_crystal_oscillator_en),
  .radio_subsystem_power(radio_subsystem_power), .irq_any(irq_any), .gpio_irq(gpio_irq), .lp_comp_irq(lp_comp_irq),
  .wakeup_pin(wakeup_pin), .freq_req_valid(freq_req_valid), .freq_req_mhz(freq_req_mhz),
  .freq_req_refused(freq_req_refused));

// ---- power_mode_pkg.sv ----
// Shared constants and types of the system power mode controller
package power_mode_pkg;
  typedef enum logic [2:0] {
    mode_active,
    mode_sleep,
    mode_deep_sleep,
    mode_hibernate,
    mode_stop,
    mode_waking
  } sys_mode_type;

  typedef enum logic [2:0] {
    radio_off,
    radio_deep_sleep,
    radio_sleep,
    radio_idle,
    radio_rx,
    radio_tx
  } radio_state_type;

  // Clock source selects
  localparam logic HF_SRC_MAIN_OSC = 1'h0;
  localparam logic HF_SRC_FAST_XTAL = 1'h1;
  localparam logic LF_SRC_LOW_SPEED_OSC = 1'h0;
  localparam logic LF_SRC_WATCH_XTAL = 1'h1;

  // Main internal oscillator frequency range, 1 MHz steps
  localparam int FREQ_W = 6;
  localparam logic [FREQ_W-1:0] MAIN_OSC_MIN_MHZ = 6'h03;
  localparam logic [FREQ_W-1:0] MAIN_OSC_MAX_MHZ = 6'h30;
  localparam logic [FREQ_W-1:0] MAIN_OSC_RST_MHZ = 6'h0c;
  localparam int FAST_XTAL_MHZ = 24;

  // High-frequency clock restart time after a wakeup
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OSC_SETTLE_NS = 2000;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 10;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(OSC_SETTLE_CYC - 1);

  // Peripheral clock dividers
  localparam int NUM_DIV = 4;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
endpackage : power_mode_pkg

// ---- wake_qualifier.sv ----
// Qualifies wakeup sources against the current low-power mode
`timescale 1ns/10ps
module wake_qualifier (
  input wire logic mclk,
  input wire logic rst,
  input power_mode_pkg::sys_mode_type mode,
  input wire logic irq_any,
  input wire logic irq_low_speed,
  input wire logic irq_async,
  input wire logic irq_lp_analog,
  input wire logic lp_comp_irq,
  input wire logic gpio_irq,
  input wire logic wakeup_pin,
  output logic wake
);
  typedef struct packed {
    logic wake;
  } wq_state_type;

  wq_state_type s_r;
  wq_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wake = 1'b0;
    unique case (mode)
      power_mode_pkg::mode_sleep: s_nxt.wake = irq_any;
      power_mode_pkg::mode_deep_sleep: s_nxt.wake = irq_low_speed | irq_async | irq_lp_analog;
      power_mode_pkg::mode_hibernate: s_nxt.wake = lp_comp_irq | gpio_irq;
      power_mode_pkg::mode_stop: s_nxt.wake = wakeup_pin;
      default: s_nxt.wake = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wake = s_r.wake;
endmodule : wake_qualifier

// ---- wake_src_model.sv ----
// Wakeup source model driving the interrupt and wakeup lines
`timescale 1ns/10ps
module wake_src_model (
  input wire logic fire,
  input wire logic [2:0] sel,
  output logic [6:0] lines
);
  // Order: any, low speed, async, analog, comparator, pin irq, wakeup pin
  assign lines = fire ? (7'h01 << sel) : 7'h00;
endmodule : wake_src_model
